/* acsp_regs.svh */
// Purpose: constants of the serial configuration port
// Assumes: 13-bit register address space, byte-wide registers
// Notes: control register addresses are fixed here for the whole block
`ifndef ACSP_REGS_SVH
`define ACSP_REGS_SVH

`define ACSP_ADDR_W 13
`define ACSP_ADDR_HI_W 5
`define ACSP_CHAN_IDX_ADDR 13'h0005
`define ACSP_CLK_CFG_ADDR 13'h0006
`define ACSP_BANK_BASE 13'h0008
`define ACSP_CHAN_SEL_RST 2'h3
`define ACSP_CLK_CFG_RST 4'h0
`define ACSP_CLK_CFG_W 4
`define ACSP_RW_BIT 7
`define ACSP_LEN_HI_BIT 6
`define ACSP_LEN_LO_BIT 5
`define ACSP_LEN_MANY 2'h3
`define ACSP_BIT_LAST 3'h7

`endif

/* acsp_pkg.sv */
// Purpose: shared types of the serial configuration port
// Assumes: nothing beyond the constants header
// Notes: clock config field order matches the register byte, bit 3 first
package acsp_pkg;

    typedef struct packed {
        logic duty_stabilizer_enable;
        logic clock_halving_select;
        logic single_ended_pin_select;
        logic single_ended;
    } acsp_clk_cfg_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INSTR_HI,
        ST_INSTR_LO,
        ST_DATA,
        ST_DONE
    } acsp_phase_type;

endpackage

/* acsp_clk_sel.sv */
// Purpose: sample clock pin choice and optional halving
// Assumes: sample clock pins are slow against sys_clk
// Notes: output is a one-cycle enable per used sample clock edge
`timescale 1ns/10ps
module acsp_clk_sel (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_clock_pos,
    input wire logic sample_clock_neg,
    input acsp_pkg::acsp_clk_cfg_type cfg,
    output logic sample_en
);

    logic pos_m, pos_q, neg_m, neg_q;
    logic lvl, lvl_q, lvl_d;
    logic half_q, half_d;
    logic en_d;

    always_comb begin
        // differential: positive leg above negative leg
        if (cfg.single_ended) begin
            lvl = cfg.single_ended_pin_select ? neg_q : pos_q;
        end else begin
            lvl = pos_q & ~neg_q;
        end
        lvl_d = lvl;
        half_d = half_q;
        en_d = 1'b0;
        if (lvl && !lvl_q) begin
            half_d = ~half_q;
            en_d = !cfg.clock_halving_select || half_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pos_m <= 1'b0;
            pos_q <= 1'b0;
            neg_m <= 1'b0;
            neg_q <= 1'b0;
            lvl_q <= 1'b0;
            half_q <= 1'b0;
            sample_en <= 1'b0;
        end else begin
            pos_m <= sample_clock_pos;
            pos_q <= pos_m;
            neg_m <= sample_clock_neg;
            neg_q <= neg_m;
            lvl_q <= lvl_d;
            half_q <= half_d;
            sample_en <= en_d;
        end
    end

endmodule

/* acsp_core.sv */
// Purpose: three-wire configuration port with channel banks and clock setup
// Assumes: host sclk well below sys_clk/4, mode: sample rising, shift falling
// Notes: serial and sample clock inputs pass two flops; sdio_oe_n low while the port drives
// Operation
// - clock, active-low select, one shared data wire
// - select-low frame carries three or more bytes
// - first byte MSB: one reads, zero writes
// - length code gives one to four-plus bytes
// - thirteen-bit address split over instruction bytes
// - address counter advances per following data byte
// - two instruction bytes come before data
// - whole bytes, most significant bit first
// - select rising ends the transfer
// - channel select steers following instructions
// - default writes both channels, reads first
// - single-ended or differential, pin choice bit
// - halving bit divides sample clock by two
// - duty stabilizer bit enables the stabilizer
`include "acsp_regs.svh"
`timescale 1ns/10ps
module acsp_core #(
    parameter int NCH = 2,
    parameter int BANK_WORDS = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_n,
    input wire logic sample_clock_pos,
    input wire logic sample_clock_neg,
    output acsp_pkg::acsp_clk_cfg_type clk_cfg,
    output logic duty_stabilizer_enable,
    output logic sample_en,
    output logic [NCH-1:0] chan_sel,
    output logic [NCH-1:0][BANK_WORDS*8-1:0] bank_out
);

    localparam int IW = $clog2(BANK_WORDS);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sclk_m, sclk_s, sclk_p;
    logic cs_m, cs_s, cs_p;
    logic sdio_m, sdio_s;
    logic sclk_rise, sclk_fall, cs_fall;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_p <= 1'b0;
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_p <= 1'b1;
            sdio_m <= 1'b0;
            sdio_s <= 1'b0;
        end else begin
            sclk_m <= sclk;
            sclk_s <= sclk_m;
            sclk_p <= sclk_s;
            cs_m <= cs_n;
            cs_s <= cs_m;
            cs_p <= cs_s;
            sdio_m <= sdio_i;
            sdio_s <= sdio_m;
        end
    end

    assign sclk_rise = sclk_s && !sclk_p;
    assign sclk_fall = !sclk_s && sclk_p;
    assign cs_fall = !cs_s && cs_p;

    ////////////////////////////////////////////////////////////////////////
    // transfer engine
    acsp_pkg::acsp_phase_type st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sr_q, sr_d, rx;
    logic [7:0] ihi_q, ihi_d;
    logic [`ACSP_ADDR_W-1:0] addr_q, addr_d, addr_new;
    logic rd_q, rd_d;
    logic [1:0] len_q, len_d, cnt_q, cnt_d;
    logic [7:0] tx_q, tx_d;
    logic tx_bit;
    logic oe_q, oe_d, dout_q, dout_d;
    logic [NCH-1:0] chan_sel_q, chan_sel_d;
    acsp_pkg::acsp_clk_cfg_type cfg_q, cfg_d;
    logic wr_stb;
    logic [IW-1:0] wr_idx;
    logic [7:0] wr_data;
    logic [BANK_WORDS*8-1:0] bank_w [NCH];

    function automatic logic in_bank(input logic [`ACSP_ADDR_W-1:0] a);
        return (a - `ACSP_BANK_BASE) < `ACSP_ADDR_W'(BANK_WORDS);
    endfunction

    // reads come from the lowest selected channel only
    function automatic logic [7:0] rdata(input logic [`ACSP_ADDR_W-1:0] a);
        logic [7:0] v;
        logic [IW-1:0] i;
        v = 8'h00;
        i = IW'(a - `ACSP_BANK_BASE);
        if (a == `ACSP_CHAN_IDX_ADDR) begin
            v = 8'(chan_sel_q);
        end else if (a == `ACSP_CLK_CFG_ADDR) begin
            v = 8'(cfg_q);
        end else if (in_bank(a)) begin
            for (int c = NCH - 1; c >= 0; c--) begin
                if (chan_sel_q[c]) begin
                    v = bank_w[c][i*8 +: 8];
                end
            end
        end
        return v;
    endfunction

    assign tx_bit = tx_q[3'h7 - bit_q];
    assign rx = {sr_q[6:0], sdio_s};
    assign addr_new = {ihi_q[`ACSP_ADDR_HI_W-1:0], rx};

    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sr_d = sr_q;
        ihi_d = ihi_q;
        addr_d = addr_q;
        rd_d = rd_q;
        len_d = len_q;
        cnt_d = cnt_q;
        tx_d = tx_q;
        oe_d = oe_q;
        dout_d = dout_q;
        chan_sel_d = chan_sel_q;
        cfg_d = cfg_q;
        wr_stb = 1'b0;
        wr_idx = IW'(addr_q - `ACSP_BANK_BASE);
        wr_data = rx;
        if (cs_s) begin
            st_d = acsp_pkg::ST_IDLE;
            oe_d = 1'b0;
            bit_d = 3'h0;
        end else if (cs_fall) begin
            st_d = acsp_pkg::ST_INSTR_HI;
            bit_d = 3'h0;
            oe_d = 1'b0;
        end else if (sclk_rise && st_q != acsp_pkg::ST_IDLE) begin
            sr_d = rx;
            bit_d = bit_q + 3'h1;
            if (bit_q == `ACSP_BIT_LAST) begin
                unique case (st_q)
                    acsp_pkg::ST_INSTR_HI: begin
                        ihi_d = rx;
                        st_d = acsp_pkg::ST_INSTR_LO;
                    end
                    acsp_pkg::ST_INSTR_LO: begin
                        addr_d = addr_new;
                        rd_d = ihi_q[`ACSP_RW_BIT];
                        len_d = ihi_q[`ACSP_LEN_HI_BIT:`ACSP_LEN_LO_BIT];
                        cnt_d = 2'h0;
                        tx_d = rdata(addr_new);
                        st_d = acsp_pkg::ST_DATA;
                    end
                    acsp_pkg::ST_DATA: begin
                        if (!rd_q) begin
                            if (addr_q == `ACSP_CHAN_IDX_ADDR) begin
                                chan_sel_d = rx[NCH-1:0];
                            end else if (addr_q == `ACSP_CLK_CFG_ADDR) begin
                                cfg_d = rx[`ACSP_CLK_CFG_W-1:0];
                            end else begin
                                wr_stb = in_bank(addr_q);
                            end
                        end
                        addr_d = addr_q + `ACSP_ADDR_W'(1);
                        tx_d = rdata(addr_q + `ACSP_ADDR_W'(1));
                        // bounded lengths stop after the coded byte count
                        if (len_q != `ACSP_LEN_MANY && cnt_q == len_q) begin
                            st_d = acsp_pkg::ST_DONE;
                        end else if (cnt_q != `ACSP_LEN_MANY) begin
                            cnt_d = cnt_q + 2'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sclk_fall && st_q == acsp_pkg::ST_DATA && rd_q) begin
            // drive on the falling edge so the host has released the wire
            oe_d = 1'b1;
            dout_d = tx_bit;
        end else if (sclk_fall && st_q == acsp_pkg::ST_DONE) begin
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= acsp_pkg::ST_IDLE;
            bit_q <= 3'h0;
            sr_q <= 8'h00;
            ihi_q <= 8'h00;
            addr_q <= '0;
            rd_q <= 1'b0;
            len_q <= 2'h0;
            cnt_q <= 2'h0;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            dout_q <= 1'b0;
            chan_sel_q <= NCH'(`ACSP_CHAN_SEL_RST);
            cfg_q <= `ACSP_CLK_CFG_RST;
        end else begin
            st_q <= st_d;
            bit_q <= bit_d;
            sr_q <= sr_d;
            ihi_q <= ihi_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            len_q <= len_d;
            cnt_q <= cnt_d;
            tx_q <= tx_d;
            oe_q <= oe_d;
            dout_q <= dout_d;
            chan_sel_q <= chan_sel_d;
            cfg_q <= cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel register banks
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [BANK_WORDS*8-1:0] bank_q, bank_d;
        always_comb begin
            bank_d = bank_q;
            if (wr_stb && chan_sel_q[c]) begin
                bank_d[wr_idx*8 +: 8] = wr_data;
            end
        end
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                bank_q <= '0;
            end else begin
                bank_q <= bank_d;
            end
        end
        assign bank_w[c] = bank_q;
        assign bank_out[c] = bank_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // sample clock and outputs
    acsp_clk_sel u_clk_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sample_clock_pos(sample_clock_pos),
        .sample_clock_neg(sample_clock_neg),
        .cfg(cfg_q),
        .sample_en(sample_en)
    );

    assign sdio_o = dout_q;
    assign sdio_oe_n = ~oe_q;
    assign clk_cfg = cfg_q;
    assign duty_stabilizer_enable = cfg_q.duty_stabilizer_enable;
    assign chan_sel = chan_sel_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic byte_done;
    assign byte_done = sclk_rise && !cs_s && !cs_fall && bit_q == 3'h7;

    property p_drive_only_read;
        !sdio_oe_n |-> (st_q == acsp_pkg::ST_DATA && rd_q)
            || st_q == acsp_pkg::ST_DONE;
    endproperty
    a_drive_only_read: assert property (p_drive_only_read)
        else $error("data pin driven outside a read");

    property p_cs_end;
        $rose(cs_s) |=> st_q == acsp_pkg::ST_IDLE && sdio_oe_n;
    endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("frame not closed on select rising");

    property p_cs_start;
        cs_fall |=> st_q == acsp_pkg::ST_INSTR_HI && bit_q == 3'h0;
    endproperty
    a_cs_start: assert property (p_cs_start)
        else $error("frame not opened on select falling");

    property p_instr_first;
        $rose(st_q == acsp_pkg::ST_DATA) |->
            $past(st_q) == acsp_pkg::ST_INSTR_LO;
    endproperty
    a_instr_first: assert property (p_instr_first)
        else $error("data phase without instruction");

    property p_dir;
        byte_done && st_q == acsp_pkg::ST_INSTR_LO |=>
            rd_q == $past(ihi_q[7]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction bit not taken");

    property p_addr;
        byte_done && st_q == acsp_pkg::ST_INSTR_LO |=>
            addr_q == $past(addr_new);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address not assembled");

    property p_incr;
        byte_done && st_q == acsp_pkg::ST_DATA |=>
            addr_q == $past(addr_q) + `ACSP_ADDR_W'(1);
    endproperty
    a_incr: assert property (p_incr)
        else $error("address counter did not advance");

    property p_len;
        byte_done && st_q == acsp_pkg::ST_DATA && len_q != 2'h3
            && cnt_q == len_q |=> st_q == acsp_pkg::ST_DONE;
    endproperty
    a_len: assert property (p_len)
        else $error("length code not honoured");

    property p_msb;
        sclk_fall && !cs_s && st_q == acsp_pkg::ST_DATA && rd_q
            && bit_q == 3'h0 |=> sdio_o == $past(tx_q[7]);
    endproperty
    a_msb: assert property (p_msb)
        else $error("read byte not sent msb first");

    property p_default_sel;
        $rose(rst_n) |-> chan_sel_q == NCH'(`ACSP_CHAN_SEL_RST);
    endproperty
    a_default_sel: assert property (p_default_sel)
        else $error("channel select default wrong");

    property p_steer;
        wr_stb && !chan_sel_q[1] |=> bank_w[1] == $past(bank_w[1]);
    endproperty
    a_steer: assert property (p_steer)
        else $error("deselected channel written");

    c_read: cover property (byte_done && st_q == acsp_pkg::ST_DATA && rd_q);
    c_write: cover property (wr_stb);
    c_done: cover property (st_q == acsp_pkg::ST_DONE && $rose(cs_s));

endmodule

/* acsp_host_model.sv */
// Purpose: serial host model driving the configuration port pins
// Assumes: sclk half period of six sys_clk cycles, data set while sclk low
// Notes: a released wire shows the inverse of its last level each cycle
`timescale 1ns/10ps
module acsp_host_model (
    input wire logic sys_clk,
    input wire logic sdio_o,
    input wire logic sdio_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic sdio_wire,
    output logic clash
);
    logic host_oe = 1'b1;
    logic host_bit = 1'b0;
    logic last_q = 1'b0;
    logic clash_q = 1'b0;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end

    // sticky: set once both ends ever drive the wire together
    assign clash = clash_q;

    // one shared data wire, device wins when it drives
    assign sdio_wire = !sdio_oe_n ? sdio_o : (host_oe ? host_bit : ~last_q);

    always @(posedge sys_clk) begin
        last_q <= sdio_wire;
        if (host_oe && sdio_oe_n === 1'b0) begin
            clash_q <= 1'b1;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one framed access; bits after the instruction come from wd, msb first
    task automatic xfer(input logic [15:0] ins, input int nbits,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic [47:0] sh;
        sh = {ins, wd};
        rd = 32'h0;
        cs_n = 1'b0;
        for (int i = 0; i < nbits + 16; i++) begin
            host_oe = !(ins[15] && i >= 16);
            host_bit = sh[47 - i];
            tick(6);
            sclk = 1'b1;
            rd = {rd[30:0], sdio_wire};
            tick(6);
            sclk = 1'b0;
        end
        tick(6);
        cs_n = 1'b1;
        tick(8);
        host_oe = 1'b1;
    endtask

    // clock and data wiggle with the port deselected
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            host_bit = ~host_bit;
            tick(6);
            sclk = ~sclk;
        end
    endtask
endmodule

/* tb_adc_config_serial_port.sv */
// Purpose: self-checking bench of the serial configuration port
// Assumes: register map and reset values of the constants header
// Notes: sample clocks driven slowly so every rise is seen
`include "acsp_regs.svh"
`timescale 1ns/10ps
module tb_adc_config_serial_port;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pos = 1'b0;
    logic neg = 1'b0;
    logic sclk, cs_n, sdio_wire, sdio_o, sdio_oe_n, clash;
    logic duty_stabilizer_enable, sample_en;
    acsp_pkg::acsp_clk_cfg_type clk_cfg;
    logic [1:0] chan_sel;
    logic [1:0][63:0] bank_out;
    logic [31:0] rd;
    int num_errors = 0;
    int num_checks = 0;
    int pulse_cnt = 0;

    always #10 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (sample_en === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
        end
    end

    acsp_core dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .sdio_i(sdio_wire), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
        .sample_clock_pos(pos), .sample_clock_neg(neg),
        .clk_cfg(clk_cfg), .duty_stabilizer_enable(duty_stabilizer_enable),
        .sample_en(sample_en), .chan_sel(chan_sel), .bank_out(bank_out)
    );

    acsp_host_model host_u (
        .sys_clk(sys_clk), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
        .sclk(sclk), .cs_n(cs_n), .sdio_wire(sdio_wire), .clash(clash)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input string what, input logic [63:0] exp,
                           input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(input logic [12:0] addr, input logic [7:0] b);
        host_u.xfer({3'b000, addr}, 8, {b, 24'h0}, rd);
    endtask

    task automatic rd1(input logic [12:0] addr, input logic [7:0] exp);
        host_u.xfer({3'b100, addr}, 8, 32'h0, rd);
        chk_val("read byte", exp, rd[7:0]);
    endtask

    task automatic run_clk(input logic [1:0] hi, input logic [1:0] lo,
                           input int exp);
        int base;
        // counter runs free; count only the pulses of this burst
        base = pulse_cnt;
        repeat (8) begin
            {pos, neg} = hi;
            host_u.tick(5);
            {pos, neg} = lo;
            host_u.tick(5);
        end
        host_u.tick(10);
        chk_cnt("sample_en pulses", exp, pulse_cnt - base);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // generous bound: seventeen frames of some 300 to 600 cycles, about 6300 cycles in all
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        $display("Error watchdog expected done seen hang");
        close_out();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        host_u.tick(4);
        chk_val("chan_sel", `ACSP_CHAN_SEL_RST, chan_sel);
        chk_val("clk_cfg", `ACSP_CLK_CFG_RST, clk_cfg);
        chk_val("bank a", 64'h0, bank_out[0]);
        chk_val("sdio_oe_n", 1'b1, sdio_oe_n);
        $display("test reset done");

        wr(13'h0008, 8'hA5);
        chk_val("bank a byte0", 8'hA5, bank_out[0][7:0]);
        chk_val("bank b byte0", 8'hA5, bank_out[1][7:0]);
        host_u.xfer(16'h6009, 32, 32'h11223344, rd);
        chk_val("bank a run", 32'h44332211, bank_out[0][39:8]);
        chk_val("bank b run", 32'h44332211, bank_out[1][39:8]);
        host_u.xfer(16'h200D, 24, 32'h55667700, rd);
        chk_val("len two cut", 24'h006655, bank_out[0][63:40]);
        host_u.xfer(16'h600E, 12, 32'h88F00000, rd);
        chk_val("partial byte", 16'h0088, bank_out[0][63:48]);
        $display("test writes done");

        // unlimited read with the wire handed over after the instruction
        host_u.xfer(16'hE008, 24, 32'h0, rd);
        chk_val("read run", 24'hA51122, rd[23:0]);
        rd1(`ACSP_CLK_CFG_ADDR, 8'h00);
        chk_val("no clash", 1'b0, clash);
        $display("test reads done");

        wr(`ACSP_CHAN_IDX_ADDR, 8'h02);
        chk_val("chan_sel b", 2'h2, chan_sel);
        wr(13'h0008, 8'h3C);
        chk_val("a kept", 8'hA5, bank_out[0][7:0]);
        chk_val("b written", 8'h3C, bank_out[1][7:0]);
        rd1(13'h0008, 8'h3C);
        rd1(`ACSP_CHAN_IDX_ADDR, 8'h02);
        // channel a alone: b must keep its byte
        wr(`ACSP_CHAN_IDX_ADDR, 8'h01);
        wr(13'h000F, 8'h5A);
        chk_val("a top written", 8'h5A, bank_out[0][63:56]);
        chk_val("b top kept", 8'h00, bank_out[1][63:56]);
        wr(`ACSP_CHAN_IDX_ADDR, 8'h03);
        rd1(13'h0008, 8'hA5);
        $display("test channels done");

        run_clk(2'b10, 2'b01, 8);
        wr(`ACSP_CLK_CFG_ADDR, 8'h0F);
        chk_val("clk_cfg all", 4'hF, clk_cfg);
        chk_val("stabilizer on", 1'b1, duty_stabilizer_enable);
        rd1(`ACSP_CLK_CFG_ADDR, 8'h0F);
        run_clk(2'b01, 2'b00, 4);
        run_clk(2'b10, 2'b00, 0);
        wr(`ACSP_CLK_CFG_ADDR, 8'h01);
        chk_val("stabilizer off", 1'b0, duty_stabilizer_enable);
        run_clk(2'b10, 2'b00, 8);
        $display("test sample clock done");

        // clocks with the port deselected must leave everything alone
        host_u.stray(16);
        chk_val("stray bank", 64'h5A885544332211A5, bank_out[0]);
        chk_val("stray oe", 1'b1, sdio_oe_n);
        chk_val("no clash end", 1'b0, clash);
        $display("test deselected done");
        close_out();
    end
endmodule
